// file: design/mmc_pkg.sv
// Shared constants, types and register map of the meter mode and mute controller
package mmc_pkg;

   // Clock rate and the 1 ms enable divider
   localparam int CLK_HZ = 125_000_000;
   localparam int TICK_TIME_US = 1000;
   localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_TIME_US;

   // Times in milliseconds, counted in 1 ms ticks
   localparam int DEBOUNCE_MS = 10;
   localparam int LAMP_TIMEOUT_MS = 3000;
   localparam int BLINK_PERIOD_MS = 1000;
   localparam int BLINK_HALF_MS = BLINK_PERIOD_MS / 2;
   localparam int MS_CNT_W = 12;

   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0c;

   // Control register fields
   localparam int CTRL_INVERT_BIT = 0;
   localparam int CTRL_ENABLE_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   // Status register fields
   localparam int ST_MODE_LSB = 0;
   localparam int ST_LAMP_BIT = 2;
   localparam int ST_TALLY_BIT = 3;
   localparam int ST_MUTE_BIT = 4;

   // Interrupt event bits
   localparam int IRQ_W = 3;
   localparam int EV_MODE_BIT = 0;
   localparam int EV_MUTE_ON_BIT = 1;
   localparam int EV_MUTE_OFF_BIT = 2;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Number of muted balanced outputs
   localparam int NUM_OUTPUTS = 18;

   // Ballistic display modes, in stepping order
   typedef enum logic [1:0] {
      MODE_AVERAGING,
      MODE_PEAK,
      MODE_COMBINED
   } mmc_mode_t;

   // Meter array control bundle
   typedef struct packed {
      logic [1:0] mode;
      logic averaging_ballistic;
      logic peak_ballistic;
      logic peak_dot;
      logic common_decay;
      logic clip_warn;
      logic blank;
   } mmc_meter_t;

   // Tri-colour lamp drive; amber is both on
   typedef struct packed {
      logic red;
      logic green;
   } mmc_lamp_t;

endpackage

// file: design/mmc_meter_mute_ctrl.sv
// Meter mode selector, status lamp, external mute handling and AXI4-Lite registers
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.

module mmc_meter_mute_ctrl
   import mmc_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES
) (
   input wire logic mclk,
   input wire logic rst_n,
   // Recessed mode push button, high while pressed
   input wire logic mode_button,
   // External mute sense, high when contact closed or voltage present
   input wire logic mute_sense,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Meter arrays, status lamp, outputs
   output mmc_meter_t meter_ctrl,
   output mmc_lamp_t status_lamp,
   output logic silence_pending_lamp,
   output logic [NUM_OUTPUTS-1:0] out_mute,
   output logic irq
);

   // Next mode in stepping order, wrapping
   function automatic mmc_mode_t step_mode(input mmc_mode_t m);
      case (m)
         MODE_AVERAGING: step_mode = MODE_PEAK;
         MODE_PEAK: step_mode = MODE_COMBINED;
         default: step_mode = MODE_AVERAGING;
      endcase
   endfunction

   // Byte lane merge for software writes
   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
      lane_merge = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            lane_merge[i*8 +: 8] = data[i*8 +: 8];
         end
      end
   endfunction

   // Millisecond divider
   logic [31:0] div_cnt; // Cycle count within one ms
   logic tick_ms; // One-cycle pulse each ms

   // Button debounce and edge
   logic btn_stable; // Debounced level
   logic [MS_CNT_W-1:0] btn_cnt; // Ms the raw level differed
   logic btn_release; // Debounced release pulse

   // Mode and lamp timer
   mmc_mode_t mode; // Selected ballistic mode
   logic lamp_on; // Mode display showing
   logic [MS_CNT_W-1:0] lamp_cnt; // Ms since last press
   logic mode_stepped; // Pulse on mode change

   // Mute path
   logic sense_meta; // First synchroniser stage
   logic sense_sync; // Second synchroniser stage
   logic mute_cmd; // Polarity-corrected command
   logic mute_act; // Command gated by enable
   logic mute_act_d; // Previous mute_act for events
   logic [MS_CNT_W-1:0] blink_cnt; // Ms within blink period

   // Registers
   logic [1:0] ctrl; // Invert and enable bits
   logic [IRQ_W-1:0] irq_stat; // Sticky events
   logic [IRQ_W-1:0] irq_mask; // Interrupt enables
   logic [IRQ_W-1:0] ev; // Events this cycle

   // Bus bookkeeping
   logic aw_got; // Write address held
   logic w_got; // Write data held
   logic [7:0] aw_addr; // Held write address
   logic [31:0] w_data; // Held write data
   logic [3:0] w_strb; // Held byte enables
   logic wr_fire; // Write performed this cycle
   logic [IRQ_W-1:0] w1c; // Bits cleared by write

   // Divider for the 1 ms enable pulse
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         div_cnt <= '0;
         tick_ms <= 1'b0;
      end else if (div_cnt == 32'(TICK_DIV - 1)) begin
         div_cnt <= '0;
         tick_ms <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 32'h1;
         tick_ms <= 1'b0;
      end
   end

   // Debounce: level must hold for the full window
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         btn_stable <= 1'b0;
         btn_cnt <= '0;
         btn_release <= 1'b0;
      end else begin
         btn_release <= 1'b0;
         if (mode_button == btn_stable) begin
            // Level agrees, restart window
            btn_cnt <= '0;
         end else if (tick_ms) begin
            if (btn_cnt == MS_CNT_W'(DEBOUNCE_MS - 1)) begin
               btn_cnt <= '0;
               btn_stable <= mode_button;
               // Act on release of a clean press
               btn_release <= btn_stable;
            end else begin
               btn_cnt <= btn_cnt + MS_CNT_W'(1);
            end
         end
      end
   end

   // Mode selection and lamp timeout
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mode <= MODE_AVERAGING;
         lamp_on <= 1'b0;
         lamp_cnt <= '0;
         mode_stepped <= 1'b0;
      end else begin
         mode_stepped <= 1'b0;
         if (btn_release) begin
            lamp_cnt <= '0;
            lamp_on <= 1'b1;
            if (lamp_on) begin
               // Lamp lit: step, colour follows at once
               mode <= step_mode(mode);
               mode_stepped <= 1'b1;
            end
         end else if (lamp_on && tick_ms) begin
            if (lamp_cnt == MS_CNT_W'(LAMP_TIMEOUT_MS - 1)) begin
               // Timeout: lamp off, mode untouched
               lamp_on <= 1'b0;
               lamp_cnt <= '0;
            end else begin
               lamp_cnt <= lamp_cnt + MS_CNT_W'(1);
            end
         end
      end
   end

   // Two-stage synchroniser on the sense input
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sense_meta <= 1'b0;
         sense_sync <= 1'b0;
      end else begin
         sense_meta <= mute_sense;
         sense_sync <= sense_meta;
      end
   end

   // Corrected command and its gated action
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mute_cmd <= 1'b0;
         mute_act <= 1'b0;
         mute_act_d <= 1'b0;
      end else begin
         // Invert bit selects absence as active
         mute_cmd <= sense_sync ^ ctrl[CTRL_INVERT_BIT];
         // Disabled: action forced off
         mute_act <= mute_cmd & ctrl[CTRL_ENABLE_BIT];
         mute_act_d <= mute_act;
      end
   end

   // Blink phase counter, restarts at each mute start
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         blink_cnt <= '0;
      end else if (!mute_act) begin
         blink_cnt <= '0;
      end else if (tick_ms) begin
         if (blink_cnt == MS_CNT_W'(BLINK_PERIOD_MS - 1)) begin
            blink_cnt <= '0;
         end else begin
            blink_cnt <= blink_cnt + MS_CNT_W'(1);
         end
      end
   end

   // Status lamp colour
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         status_lamp <= '0;
      end else if (mute_act) begin
         // Red half on, half off, overrides mode display
         status_lamp.red <= (blink_cnt < MS_CNT_W'(BLINK_HALF_MS));
         status_lamp.green <= 1'b0;
      end else if (lamp_on) begin
         // Mode colour; normal once mute lifts
         case (mode)
            MODE_AVERAGING: status_lamp <= '{red: 1'b0, green: 1'b1};
            MODE_PEAK: status_lamp <= '{red: 1'b1, green: 1'b0};
            default: status_lamp <= '{red: 1'b1, green: 1'b1};
         endcase
      end else begin
         status_lamp <= '0;
      end
   end

   // Meter array control
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         meter_ctrl <= '0;
      end else begin
         meter_ctrl.mode <= mode;
         meter_ctrl.averaging_ballistic <= (mode != MODE_PEAK);
         meter_ctrl.peak_ballistic <= (mode != MODE_AVERAGING);
         // Peak as single dot above bar
         meter_ctrl.peak_dot <= (mode == MODE_COMBINED);
         // Dot and bar share decay so dot stays above
         meter_ctrl.common_decay <= (mode == MODE_COMBINED);
         // Top red segment used as clip warning
         meter_ctrl.clip_warn <= (mode == MODE_AVERAGING);
         // All four arrays dark while muted
         meter_ctrl.blank <= mute_act;
      end
   end

   // Output mutes and pending lamp
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         out_mute <= '0;
         silence_pending_lamp <= 1'b0;
      end else begin
         // Every output together
         out_mute <= {NUM_OUTPUTS{mute_act}};
         // Shows command regardless of enable
         silence_pending_lamp <= mute_cmd;
      end
   end

   // Events feeding the sticky status
   assign ev[EV_MODE_BIT] = mode_stepped;
   assign ev[EV_MUTE_ON_BIT] = mute_act & ~mute_act_d;
   assign ev[EV_MUTE_OFF_BIT] = ~mute_act & mute_act_d;

   // Write takes effect once address and data are both held
   assign wr_fire = aw_got && w_got && !s_axi_bvalid;
   assign w1c = (wr_fire && aw_addr == REG_IRQ_STAT && w_strb[0]) ?
                w_data[IRQ_W-1:0] : '0;

   // Write address channel
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         aw_got <= 1'b0;
         aw_addr <= '0;
         s_axi_awready <= 1'b1;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_got <= 1'b1;
         aw_addr <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         aw_got <= 1'b0;
         s_axi_awready <= 1'b1;
      end
   end

   // Write data channel
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         w_got <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
         s_axi_wready <= 1'b1;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_got <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         w_got <= 1'b0;
         s_axi_wready <= 1'b1;
      end
   end

   // Write response; unmapped addresses get an error
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         case (aw_addr)
            REG_CTRL, REG_STATUS, REG_IRQ_STAT, REG_IRQ_MASK: s_axi_bresp <= RESP_OKAY;
            default: s_axi_bresp <= RESP_SLVERR;
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control and mask registers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl <= CTRL_RESET;
         irq_mask <= '0;
      end else if (wr_fire) begin
         if (aw_addr == REG_CTRL) begin
            ctrl <= 2'(lane_merge(32'(ctrl), w_data, w_strb));
         end
         if (aw_addr == REG_IRQ_MASK) begin
            irq_mask <= IRQ_W'(lane_merge(32'(irq_mask), w_data, w_strb));
         end
      end
   end

   // Sticky events, write one to clear; a new event wins
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         irq_stat <= '0;
      end else begin
         irq_stat <= (irq_stat & ~w1c) | ev;
      end
   end

   // Level interrupt from unmasked status
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat & irq_mask);
      end
   end

   // Read channel, one read at a time
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         s_axi_rdata <= '0;
         case (s_axi_araddr)
            REG_CTRL: s_axi_rdata[1:0] <= ctrl;
            REG_STATUS: begin
               s_axi_rdata[ST_MODE_LSB +: 2] <= mode;
               s_axi_rdata[ST_LAMP_BIT] <= lamp_on;
               s_axi_rdata[ST_TALLY_BIT] <= mute_cmd;
               s_axi_rdata[ST_MUTE_BIT] <= mute_act;
            end
            REG_IRQ_STAT: s_axi_rdata[IRQ_W-1:0] <= irq_stat;
            REG_IRQ_MASK: s_axi_rdata[IRQ_W-1:0] <= irq_mask;
            default: s_axi_rresp <= RESP_SLVERR;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule

// file: bench/mmc_props.sv
// Concurrent checks on meter mode, status lamp and mute outputs
module mmc_props
   import mmc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire mmc_meter_t meter_ctrl,
   input wire mmc_lamp_t status_lamp,
   input wire logic silence_pending_lamp,
   input wire logic [NUM_OUTPUTS-1:0] out_mute
);
   // One clock domain, reset held off every check
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   outputs_equal_a: assert property (out_mute == '0 || out_mute == '1)
      else $error("outputs not muted together");
   mute_blank_a: assert property (out_mute[0] == meter_ctrl.blank)
      else $error("meter blanking differs from output mute");
   mute_red_a: assert property (out_mute[0] |-> !status_lamp.green)
      else $error("green lamp during mute");
   pending_lead_a: assert property (out_mute[0] |-> $past(silence_pending_lamp))
      else $error("mute without pending lamp");
   avg_clip_a: assert property ($past(rst_n) && !meter_ctrl.blank
      && meter_ctrl.mode == MODE_AVERAGING |-> meter_ctrl.clip_warn
      && meter_ctrl.averaging_ballistic && !meter_ctrl.peak_ballistic)
      else $error("averaging mode fields wrong");
   peak_mode_a: assert property (!meter_ctrl.blank && meter_ctrl.mode == MODE_PEAK
      |-> meter_ctrl.peak_ballistic && !meter_ctrl.averaging_ballistic && !meter_ctrl.clip_warn)
      else $error("peak mode fields wrong");
   comb_dot_a: assert property (!meter_ctrl.blank && meter_ctrl.mode == MODE_COMBINED
      |-> meter_ctrl.peak_dot && meter_ctrl.common_decay && meter_ctrl.averaging_ballistic)
      else $error("combined mode fields wrong");
   mode_step_a: assert property ($past(rst_n) && !meter_ctrl.blank && !$past(meter_ctrl.blank)
      && $changed(meter_ctrl.mode) |-> meter_ctrl.mode ==
      ($past(meter_ctrl.mode) == 2'h2 ? 2'h0 : $past(meter_ctrl.mode) + 2'h1))
      else $error("mode stepped out of order");
   mode_lit_a: assert property ($past(rst_n) && !meter_ctrl.blank && !$past(meter_ctrl.blank)
      && $changed(meter_ctrl.mode) |-> $past(status_lamp != 2'b00))
      else $error("mode changed while lamp dark");

   // Main scenarios reached
   cover property ($rose(out_mute[0]));
   cover property ($changed(meter_ctrl.mode));
   cover property (status_lamp == 2'b11);
endmodule

bind mmc_meter_mute_ctrl mmc_props u_props (.mclk(mclk), .rst_n(rst_n),
   .meter_ctrl(meter_ctrl), .status_lamp(status_lamp),
   .silence_pending_lamp(silence_pending_lamp), .out_mute(out_mute));

// file: bench/mmc_sense_src.sv
// External mute source: relay contact or voltage on the sense input
module mmc_sense_src (
   input wire logic mute_req,
   input wire logic open_means_mute,
   output wire logic sense
);
   timeunit 1ns;
   timeprecision 1ps;
   // Closes or opens, unrelated to the clock, as wired
   assign #3 sense = mute_req ^ open_means_mute;
endmodule

// file: bench/tb_top.sv
// Self-checking bench for the meter mode and mute controller
module tb_top
   import mmc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic mode_button = 1'b0;
   logic mute_req = 1'b0;
   logic open_mute = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic sense, awready, wready, bvalid, arready, rvalid, irq, pend;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, rd;
   mmc_meter_t meter;
   mmc_lamp_t lamp;
   logic [NUM_OUTPUTS-1:0] out_mute;
   int failures = 0, checks_done = 0;

   // 125 MHz clock
   always #4 mclk = ~mclk;

   // Design with a 4 cycle millisecond tick
   mmc_meter_mute_ctrl #(.TICK_DIV(4)) dut (.mclk(mclk), .rst_n(rst_n),
      .mode_button(mode_button), .mute_sense(sense), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(1'b1), .meter_ctrl(meter), .status_lamp(lamp),
      .silence_pending_lamp(pend), .out_mute(out_mute), .irq(irq));

   // Far side contact or voltage source
   mmc_sense_src u_src (.mute_req(mute_req), .open_means_mute(open_mute), .sense(sense));

   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic w(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // One register write, response kept in resp
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      // Waits for the answer; only the watchdog ends a hang
      forever begin
         @(posedge mclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            resp = bresp;
            return;
         end
      end
   endtask

   // One register read, word kept in rd
   task automatic axi_rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      // Waits for the answer; only the watchdog ends a hang
      forever begin
         @(posedge mclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            rd = rdata;
            resp = rresp;
            return;
         end
      end
   endtask

   // Hold the button, release, let debounce and action settle
   task automatic press(input int hold);
      mode_button <= 1'b1;
      w(hold);
      mode_button <= 1'b0;
      w(100);
   endtask

   task automatic t_reset;
      chk(out_mute, 0);
      chk(lamp, 0);
      chk(meter.mode, MODE_AVERAGING);
      chk(meter.clip_warn, 1);
      chk(irq, 0);
      axi_rd(REG_CTRL);
      chk(rd, 0);
   endtask

   task automatic t_regs;
      axi_wr(REG_IRQ_MASK, 32'h1);
      chk(resp, RESP_OKAY);
      axi_rd(REG_IRQ_MASK);
      chk(rd, 32'h1);
      axi_rd(8'h40);
      chk(rd, 32'h0);
      chk(resp, RESP_SLVERR);
      axi_wr(8'h40, 32'h5);
      chk(resp, RESP_SLVERR);
   endtask

   // Glitch, show mode, then step through all modes
   task automatic t_modes;
      mmc_mode_t modes [3] = '{MODE_PEAK, MODE_COMBINED, MODE_AVERAGING};
      logic [1:0] cols [3] = '{2'b10, 2'b11, 2'b01};
      press(6);
      chk(lamp, 0);
      press(80);
      chk({lamp, meter.mode}, {2'b01, MODE_AVERAGING});
      for (int i = 0; i < 3; i++) begin
         press(80);
         chk({lamp, meter.mode}, {cols[i], modes[i]});
      end
      chk(irq, 1);
      axi_wr(REG_IRQ_STAT, 32'h1);
      w(3);
      chk(irq, 0);
   endtask

   task automatic t_timeout;
      w(11000);
      chk(lamp, 2'b01);
      w(1500);
      chk({lamp, meter.mode}, {2'b00, MODE_AVERAGING});
      axi_rd(REG_STATUS);
      chk(rd, 0);
   endtask

   // Pending only, enabled mute, blink, inverted sense, release
   task automatic t_mute;
      int n;
      axi_wr(REG_IRQ_STAT, 32'h7);
      mute_req <= 1'b1;
      w(20);
      chk({pend, out_mute, meter.blank}, {1'b1, 19'h0});
      axi_wr(REG_CTRL, 32'h2);
      w(10);
      chk(out_mute, {NUM_OUTPUTS{1'b1}});
      chk({meter.blank, lamp.green, irq}, 3'b100);
      axi_rd(REG_IRQ_STAT);
      chk(rd, 32'h2);
      // Status shows command and active mute, mode display off
      axi_rd(REG_STATUS);
      chk(rd, 32'h18);
      n = 0;
      while (lamp.red && n < 2100) begin
         w(1);
         n++;
      end
      n = 0;
      while (!lamp.red && n < 2100) begin
         w(1);
         n++;
      end
      chk(n, 2000);
      axi_wr(REG_CTRL, 32'h3);
      w(10);
      chk({pend, out_mute, meter.blank, lamp}, 0);
      open_mute <= 1'b1;
      w(10);
      chk({pend, out_mute}, {1'b1, {NUM_OUTPUTS{1'b1}}});
      mute_req <= 1'b0;
      w(10);
      chk({out_mute, meter.blank}, 0);
      axi_rd(REG_IRQ_STAT);
      chk(rd, 32'h6);
   endtask

   task automatic end_sim;
      if (failures == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      w(3);
      t_reset;
      t_regs;
      t_modes;
      t_timeout;
      t_mute;
      end_sim;
   end

   // Hang guard, about twice the expected run
   initial begin
      repeat (40000) @(posedge mclk);
      failures++;
      end_sim;
   end
endmodule
